// >>> spms_axil.sv
// AXI4-Lite slave that turns bus transfers into register strobes
`include "spms_defs.svh"
module spms_axil
  import spms_pkg::*;
(
  input wire logic clk, // Bus clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [31:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte enables
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [31:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  spms_regif_if.bus rif // Strobes to the core
);
  spms_axil_t s;
  spms_axil_t next_s;

  // Mapped words only, aligned, below the top of the map
  function automatic logic addr_ok(input logic [31:0] a);
    addr_ok = (a[31:`SPMS_AW] == '0) && (a[1:0] == 2'b00);
  endfunction

  // Channel handshakes and strobe generation
  always_comb begin
    next_s = s;
    next_s.wr = 1'b0;
    next_s.rd = 1'b0;
    if (awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = awaddr[`SPMS_AW-1:0];
      next_s.aw_ok = addr_ok(awaddr);
    end
    if (wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      for (int i = 0; i < 4; i++) begin
        next_s.wdata[i*8 +: 8] = wstrb[i] ? wdata[i*8 +: 8] : 8'h00;
      end
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.wr = s.aw_ok;
      next_s.bvalid = 1'b1;
      next_s.bresp = s.aw_ok ? `SPMS_RESP_OK : `SPMS_RESP_ERR;
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      next_s.ar_pend = 1'b1;
      next_s.araddr = araddr[`SPMS_AW-1:0];
      next_s.ar_ok = addr_ok(araddr);
      next_s.rd = addr_ok(araddr);
    end
    if (s.ar_pend) begin
      next_s.ar_pend = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = s.ar_ok ? rif.rdata : 32'h0000_0000;
      next_s.rresp = s.ar_ok ? `SPMS_RESP_OK : `SPMS_RESP_ERR;
    end
    next_s.arready = !next_s.ar_pend && !next_s.rvalid;
  end

  // State register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign rif.wr = s.wr;
  assign rif.waddr = s.awaddr;
  assign rif.wdata = s.wdata;
  assign rif.rd = s.rd;
  assign rif.raddr = s.araddr;
endmodule

// >>> spms_defs.svh
// Register map, field positions, reset values and counts of the serial port controller
`ifndef SPMS_DEFS_SVH
`define SPMS_DEFS_SVH
`define SPMS_AW 4
`define SPMS_OFF_CTRL 4'h0
`define SPMS_OFF_TX 4'h4
`define SPMS_OFF_STAT 4'h8
`define SPMS_OFF_RX 4'hc
`define SPMS_CTRL_W 9
`define SPMS_CTRL_RST 9'h000
`define SPMS_B_RATE_HI 2
`define SPMS_B_CPOL 3
`define SPMS_B_CPHA 4
`define SPMS_B_SPX 5
`define SPMS_B_DIR 6
`define SPMS_B_EN 7
`define SPMS_B_HOLD 8
`define SPMS_RATE_MAX 3'h5
`define SPMS_LAST_EDGE 4'hf
`define SPMS_CNT_W 12
`define SPMS_RESP_OK 2'b00
`define SPMS_RESP_ERR 2'b10
`endif

// >>> spms_dev_model.sv
// Behavioural serial slave device facing the controller
module spms_dev_model (
  input wire logic sck, // Serial clock
  input wire logic ss_n, // Select, active low
  input wire logic mosi, // Data from master
  input wire logic cpol, // Clock polarity
  input wire logic cpha, // Clock phase
  input wire logic quiet, // Shared line owned by master
  input wire logic [7:0] tx_byte, // Byte to return
  input wire logic [15:0] lag_ns, // Output settle delay
  output logic dout, // Data to master
  output logic [7:0] rx_byte, // Last byte taken
  output logic [7:0] rx_cnt // Bytes taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_out = 8'h00;
  logic [7:0] sh_in = 8'h00;
  logic [3:0] bits = 4'h0;
  initial dout = 1'b0;
  initial rx_cnt = 8'h00;
  initial rx_byte = 8'h00;
  // Next bit out after the settle delay
  task automatic push;
    if (!quiet) dout <= #(lag_ns) sh_out[7];
    sh_out = {sh_out[6:0], 1'b0};
  endtask
  // Released line shows the inverse of its last level
  always @(posedge ss_n or posedge quiet) dout <= ~dout;
  // Frame start, first-edge capture needs the first bit ready
  always @(negedge ss_n) begin
    bits = 4'h0;
    sh_out = tx_byte;
    if (!cpha) push();
  end
  // Answer only on the master's clock while selected
  always @(sck) begin
    if (!ss_n) begin
      if ((sck !== cpol) == !cpha) begin
        sh_in = {sh_in[6:0], mosi};
        bits = bits + 4'h1;
        if (bits == 4'h8) begin
          rx_byte = sh_in;
          rx_cnt = rx_cnt + 8'h01;
          bits = 4'h0;
        end
      end else begin
        if (cpha && bits == 4'h0) sh_out = tx_byte;
        push();
      end
    end
  end
endmodule

// >>> spms_master.sv
// Serial bus master that drives the serial port of a peripheral device
// Summary of operation
// - Bytes move most significant bit first
// - Only the master starts and clocks transfers
// - Shared data line carries one direction only
// - Slave clock at most half its CPU clock
// - Master's internal select stays high always
// - Second-edge capture keeps select low throughout; here only while the HOLD control bit is set
// - First-edge capture raises select between bytes
// - Configure timing before enabling the port
// - Clear done before next byte ends, else overrun
// - Slave setup: timing first, then enable
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`include "spms_defs.svh"
module spms_master
  import spms_pkg::*;
#(
  parameter int unsigned MIN_HALF = 4
) (
  input wire logic REF_CLK, // System clock
  input wire logic NRST, // Synchronous reset, active low
  input wire logic [31:0] S_AXI_AWADDR, // Write address
  input wire logic S_AXI_AWVALID, // Write address valid
  output logic S_AXI_AWREADY, // Write address ready
  input wire logic [31:0] S_AXI_WDATA, // Write data
  input wire logic [3:0] S_AXI_WSTRB, // Write byte enables
  input wire logic S_AXI_WVALID, // Write data valid
  output logic S_AXI_WREADY, // Write data ready
  output logic [1:0] S_AXI_BRESP, // Write response
  output logic S_AXI_BVALID, // Write response valid
  input wire logic S_AXI_BREADY, // Write response ready
  input wire logic [31:0] S_AXI_ARADDR, // Read address
  input wire logic S_AXI_ARVALID, // Read address valid
  output logic S_AXI_ARREADY, // Read address ready
  output logic [31:0] S_AXI_RDATA, // Read data
  output logic [1:0] S_AXI_RRESP, // Read response
  output logic S_AXI_RVALID, // Read data valid
  input wire logic S_AXI_RREADY, // Read data ready
  output logic SCK, // Serial clock to the device
  output logic SS_N, // Device select, active low
  output logic MOSI_O, // Master data out
  output logic MOSI_OE, // Master data drive enable
  input wire logic MOSI_I, // Master data line level
  input wire logic MISO // Device data in
);
  spms_core_t s;
  spms_core_t next_s;
  spms_regif_if rif ();
  logic [1:0] pin_q;
  logic [2:0] rate_eff;
  logic [11:0] half_m1;
  logic din;
  logic tick;
  logic en;
  logic wr_tx;
  logic clr_done;
  logic tx_ok;
  logic [7:0] samp;

  // Bus slave
  spms_axil u_axil (
    .clk(REF_CLK),
    .nrst(NRST),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .rif(rif.bus)
  );

  // Pin inputs, bit 1 shared line, bit 0 device data
  spms_sync #(.W(2)) u_sync (
    .clk(REF_CLK),
    .nrst(NRST),
    .d({MOSI_I, MISO}),
    .q(pin_q)
  );

  // Decoded strobes and clock divider terms
  always_comb begin
    en = s.ctrl[`SPMS_B_EN];
    wr_tx = rif.wr && (rif.waddr == `SPMS_OFF_TX);
    // Done clears only after a status access that saw it set
    clr_done = rif.rd && (rif.raddr == `SPMS_OFF_RX) && s.stat_rd;
    // Data writes inhibited while done is set and status not yet read
    tx_ok = wr_tx && en && (!s.done || s.stat_rd);
    rate_eff = (s.rate > `SPMS_RATE_MAX) ? `SPMS_RATE_MAX : s.rate;
    half_m1 = (`SPMS_CNT_W'(MIN_HALF) << rate_eff) - `SPMS_CNT_W'(1);
    din = (s.spx && !s.dir) ? pin_q[1] : pin_q[0];
    tick = (s.cnt == '0);
    samp = {s.rx_sh[6:0], din};
  end

  // Register read mux
  always_comb begin
    case (rif.raddr)
      `SPMS_OFF_CTRL: rif.rdata = {23'h000000, s.ctrl};
      `SPMS_OFF_TX: rif.rdata = {24'h000000, s.tx};
      `SPMS_OFF_STAT: rif.rdata = {28'h0000000, s.overrun_flag, s.write_collision_flag, s.done, s.state != ST_IDLE};
      `SPMS_OFF_RX: rif.rdata = {24'h000000, s.rx};
      default: rif.rdata = 32'h0000_0000;
    endcase
  end

  // Transfer engine and status flags
  always_comb begin
    next_s = s;
    if (rif.wr && (rif.waddr == `SPMS_OFF_CTRL)) begin
      next_s.ctrl = rif.wdata[`SPMS_CTRL_W-1:0];
    end
    if (rif.rd && (rif.raddr == `SPMS_OFF_STAT)) begin
      next_s.write_collision_flag = 1'b0;
      next_s.overrun_flag = 1'b0;
      if (s.done) begin
        next_s.stat_rd = 1'b1;
      end
    end
    if (clr_done) begin
      next_s.done = 1'b0;
      next_s.stat_rd = 1'b0;
    end
    case (s.state)
      ST_IDLE: begin
        // Timing taken from control only between bytes
        next_s.cpol = s.ctrl[`SPMS_B_CPOL];
        next_s.cpha = s.ctrl[`SPMS_B_CPHA];
        next_s.rate = s.ctrl[`SPMS_B_RATE_HI:0];
        next_s.spx = s.ctrl[`SPMS_B_SPX];
        next_s.dir = s.ctrl[`SPMS_B_DIR];
        next_s.sck = s.ctrl[`SPMS_B_CPOL];
        next_s.mosi_oe = en && !(s.ctrl[`SPMS_B_SPX] && !s.ctrl[`SPMS_B_DIR]);
        if (!s.ctrl[`SPMS_B_HOLD] || !en || !s.ctrl[`SPMS_B_CPHA]) begin
          next_s.keep = 1'b0;
        end
        next_s.ss_n = !next_s.keep;
        if (tx_ok) begin
          next_s.tx = rif.wdata[7:0];
          next_s.state = ST_SHIFT;
          next_s.ss_n = 1'b0;
          next_s.cnt = half_m1;
          next_s.eix = '0;
        end
      end
      ST_SHIFT: begin
        if (!tick) begin
          next_s.cnt = s.cnt - `SPMS_CNT_W'(1);
        end else if (!en) begin
          // Abort only on a clock boundary
          next_s.state = ST_IDLE;
          next_s.sck = s.cpol;
          next_s.ss_n = 1'b1;
          next_s.keep = 1'b0;
        end else begin
          next_s.sck = !s.sck;
          next_s.cnt = half_m1;
          next_s.eix = s.eix + 4'h1;
          if (s.eix[0] == s.cpha) begin
            next_s.rx_sh = samp;
          end
          if ((s.eix[0] != s.cpha) && (s.eix != '0) && (s.eix != `SPMS_LAST_EDGE)) begin
            next_s.tx = {s.tx[6:0], 1'b0};
          end
          if (s.eix == `SPMS_LAST_EDGE) begin
            // Unread byte is kept; the newer one is lost on overrun
            if (s.done && !clr_done) begin
              next_s.overrun_flag = 1'b1;
            end else begin
              next_s.rx = (s.cpha) ? samp : s.rx_sh;
            end
            next_s.done = 1'b1;
            next_s.stat_rd = 1'b0;
            next_s.state = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        if (!tick) begin
          next_s.cnt = s.cnt - `SPMS_CNT_W'(1);
        end else begin
          // Select held across bytes only for second-edge capture
          next_s.keep = s.cpha && s.ctrl[`SPMS_B_HOLD] && en;
          next_s.ss_n = !next_s.keep;
          next_s.state = ST_IDLE;
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase
    if (wr_tx && (s.state != ST_IDLE)) begin
      next_s.write_collision_flag = 1'b1;
    end
    next_s.mosi = next_s.tx[7];
  end

  // State register
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      s <= '0;
      s.ctrl <= `SPMS_CTRL_RST;
      s.ss_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign SCK = s.sck;
  assign SS_N = s.ss_n;
  assign MOSI_O = s.mosi;
  assign MOSI_OE = s.mosi_oe;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  // Clock rests at the chosen polarity when no byte moves
  AST_IDLE_SCK: assert property (s.state == ST_IDLE |-> SCK == s.cpol)
    else $error("serial clock not at idle polarity");

  // No clock edges without the device selected
  AST_CLK_SELECTED: assert property (SCK != s.cpol |-> !SS_N)
    else $error("clock toggled while device not selected");

  // Disabled controller leaves select high
  AST_SS_OFF: assert property (!en ##1 !en |-> SS_N)
    else $error("select low while controller disabled");

  // First-edge capture releases select after each byte
  AST_CPHA0_GAP: assert property ((s.state == ST_GAP && tick && !s.cpha) |=> SS_N)
    else $error("select not raised between first-edge bytes");

  // Select kept low between bytes only for second-edge capture
  AST_KEEP_CPHA1: assert property ((s.state == ST_IDLE && !SS_N) |-> s.cpha)
    else $error("select held low between first-edge bytes");

  // Most significant bit presented first
  // Data write ignored while done is set and status unread
  AST_TX_INHIBIT: assert property ((s.state == ST_IDLE && wr_tx && s.done && !s.stat_rd)
    |=> s.state == ST_IDLE)
    else $error("data write started a byte while done was unread");

  AST_MSB_FIRST: assert property ((s.state == ST_IDLE && tx_ok)
    |=> MOSI_O == $past(rif.wdata[7]) && !SS_N)
    else $error("first bit out is not the msb");

  // Half period never shorter than four clocks
  AST_HALF_MIN: assert property ($changed(SCK) |=> $stable(SCK) [*3])
    else $error("serial clock half period too short");

  // Receive on the shared line never drives it
  AST_SIMPLEX_RX: assert property ((s.spx && !s.dir) |-> !MOSI_OE)
    else $error("shared line driven while receiving");

  // Unread byte at the next byte end flags overrun
  AST_OVERRUN: assert property ((s.state == ST_SHIFT && tick && en && s.eix == `SPMS_LAST_EDGE
    && s.done && !clr_done) |=> s.overrun_flag && s.done)
    else $error("overrun not flagged");

  // Timing fields frozen during a byte
  AST_CFG_HOLD: assert property ((s.state != ST_IDLE) |=> $stable(s.cpol) && $stable(s.cpha))
    else $error("timing changed mid byte");

  COV_CPHA0: cover property (s.state == ST_GAP && tick && !s.cpha);
  COV_CPHA1: cover property (s.state == ST_GAP && tick && s.cpha && s.ctrl[`SPMS_B_HOLD]);
  COV_SIMPLEX: cover property (s.state == ST_SHIFT && s.spx && !s.dir && tick);
  COV_OVR: cover property (!s.overrun_flag ##1 s.overrun_flag);
endmodule

// >>> spms_master_tb_top.sv
// Self-checking bench for the serial port controller
`include "spms_defs.svh"
module spms_master_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_CTRL = {28'h0, `SPMS_OFF_CTRL};
  localparam logic [31:0] A_TX = {28'h0, `SPMS_OFF_TX};
  localparam logic [31:0] A_STAT = {28'h0, `SPMS_OFF_STAT};
  localparam logic [31:0] A_RX = {28'h0, `SPMS_OFF_RX};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, sck, ss_n, mosi_o, mosi_oe, dout;
  logic [1:0] bresp, rresp;
  logic cpol = 1'b0, cpha = 1'b0, quiet = 1'b0, spx = 1'b0;
  logic [7:0] dev_tx = 8'h00, dev_rx, dev_cnt;
  logic [15:0] lag = 16'h0;
  wire logic mosi_w = mosi_oe ? mosi_o : dout;
  int err_count = 0;
  int cmp_count = 0;
  initial forever #20 clk = ~clk;
  spms_master #(.MIN_HALF(4)) spms_master_inst (
    .REF_CLK(clk),
    .NRST(nrst),
    .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready),
    .SCK(sck),
    .SS_N(ss_n),
    .MOSI_O(mosi_o),
    .MOSI_OE(mosi_oe),
    .MOSI_I(mosi_w),
    .MISO(spx ? mosi_w : dout)
  );
  spms_dev_model spms_dev_model_inst (
    .sck(sck),
    .ss_n(ss_n),
    .mosi(mosi_w),
    .cpol(cpol),
    .cpha(cpha),
    .quiet(quiet),
    .tx_byte(dev_tx),
    .lag_ns(lag),
    .dout(dout),
    .rx_byte(dev_rx),
    .rx_cnt(dev_cnt)
  );
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic aw_d, w_d, b_d;
    aw_d = 0;
    w_d = 0;
    b_d = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_d) begin
      @(posedge clk);
      if (aw_d && w_d && bvalid === 1'b1) begin
        r = bresp;
        b_d = 1;
        bready <= 1'b0;
      end
      if (!aw_d && awready === 1'b1) begin
        aw_d = 1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready === 1'b1) begin
        w_d = 1;
        wvalid <= 1'b0;
      end
    end
  endtask
  // Bus read
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_d, r_d;
    ar_d = 0;
    r_d = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_d) begin
      @(posedge clk);
      if (ar_d && rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        r_d = 1;
        rready <= 1'b0;
      end
      if (!ar_d && arready === 1'b1) begin
        ar_d = 1;
        arvalid <= 1'b0;
      end
    end
  endtask
  task automatic put(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hf, r);
  endtask
  task automatic get(input logic [31:0] a, output logic [31:0] d);
    logic [1:0] r;
    rd(a, d, r);
  endtask
  task automatic wait_idle(output logic [31:0] v);
    do get(A_STAT, v);
    while (v[0] !== 1'b0);
  endtask
  task automatic wait_dev(input logic [7:0] c0);
    while (dev_cnt === c0) @(posedge clk);
    repeat (12) @(posedge clk);
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    logic [8:0] ctl;
    logic [7:0] c0;
    int n;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk_pin(sck, 1'b0);
    chk_pin(ss_n, 1'b1);
    get(A_CTRL, v);
    chk_word(v, 32'h0);
    wr(A_CTRL, 32'h000001ff, 4'h2, r);
    get(A_CTRL, v);
    chk_word(v, 32'h00000100);
    wr(32'h00000010, 32'h1, 4'hf, r);
    chk_word({30'h0, r}, {30'h0, `SPMS_RESP_ERR});
    rd(32'h00000010, v, r);
    chk_word({30'h0, r}, {30'h0, `SPMS_RESP_ERR});
    chk_word(v, 32'h0);
    // Disabled port ignores a data write
    c0 = dev_cnt;
    put(A_TX, 32'h000000ff);
    repeat (40) @(posedge clk);
    chk_pin(ss_n, 1'b1);
    chk_word({24'h0, dev_cnt}, {24'h0, c0});
    // Every mode and rate, slow device answer at rate five
    for (int i = 0; i < 7; i++) begin
      ctl = {2'b01, 2'b00, i[1], i[0], 3'(i > 5 ? 7 : i)};
      cpol <= ctl[3];
      cpha <= ctl[4];
      lag <= (i == 5) ? 16'd3000 : 16'd0;
      dev_tx <= 8'ha5 ^ 8'(i);
      put(A_CTRL, {23'h0, ctl});
      put(A_TX, 32'h3c + 32'(i));
      while (sck === ctl[3]) @(posedge clk);
      n = 0;
      while (sck !== ctl[3]) begin
        @(posedge clk);
        n++;
      end
      chk_word(32'(n), 32'(4 << (i > 5 ? 5 : i)));
      wait_idle(v);
      chk_pin(ss_n, 1'b1);
      chk_pin(sck, ctl[3]);
      chk_word(v & 32'h2, 32'h2);
      get(A_RX, v);
      chk_word(v, {24'h0, 8'ha5 ^ 8'(i)});
      chk_word({24'h0, dev_rx}, 32'h3c + 32'(i));
      get(A_STAT, v);
      chk_word(v & 32'h2, 32'h0);
    end
    // Second data write lands mid-byte
    cpol <= 1'b0;
    cpha <= 1'b0;
    lag <= 16'd0;
    put(A_CTRL, 32'h00000080);
    c0 = dev_cnt;
    put(A_TX, 32'h000000c3);
    put(A_TX, 32'h0000003c);
    get(A_STAT, v);
    chk_word(v & 32'h5, 32'h5);
    wait_dev(c0);
    chk_word({24'h0, dev_rx}, 32'h000000c3);
    chk_word({24'h0, dev_cnt}, {24'h0, c0 + 8'h01});
    get(A_STAT, v);
    chk_word(v & 32'h6, 32'h2);
    get(A_RX, v);
    // Unread byte blocks writes, then a second byte overruns
    c0 = dev_cnt;
    dev_tx <= 8'h81;
    put(A_TX, 32'h00000011);
    wait_dev(c0);
    put(A_TX, 32'h00000022);
    repeat (12) @(posedge clk);
    chk_pin(ss_n, 1'b1);
    chk_word({24'h0, dev_cnt}, {24'h0, c0 + 8'h01});
    get(A_STAT, v);
    dev_tx <= 8'h42;
    put(A_TX, 32'h00000022);
    wait_dev(c0 + 8'h01);
    chk_word({24'h0, dev_rx}, 32'h00000022);
    get(A_STAT, v);
    chk_word(v & 32'ha, 32'ha);
    get(A_RX, v);
    chk_word(v, 32'h00000081);
    get(A_STAT, v);
    chk_word(v & 32'ha, 32'h0);
    // Shared line, receive then transmit
    spx <= 1'b1;
    dev_tx <= 8'h96;
    put(A_CTRL, 32'h000000a0);
    c0 = dev_cnt;
    put(A_TX, 32'h0);
    repeat (20) @(posedge clk);
    chk_pin(mosi_oe, 1'b0);
    wait_dev(c0);
    get(A_STAT, v);
    get(A_RX, v);
    chk_word(v, 32'h00000096);
    quiet <= 1'b1;
    put(A_CTRL, 32'h000000e0);
    c0 = dev_cnt;
    put(A_TX, 32'h0000005a);
    wait_dev(c0);
    chk_word({24'h0, dev_rx}, 32'h0000005a);
    tally_and_finish();
  end
endmodule

// >>> spms_pkg.sv
// Types shared by the serial port controller modules
package spms_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} spms_state_t;

  typedef struct packed {
    spms_state_t state;
    logic [8:0] ctrl;
    logic cpol;
    logic cpha;
    logic spx;
    logic dir;
    logic [2:0] rate;
    logic keep;
    logic [7:0] tx;
    logic [7:0] rx_sh;
    logic [7:0] rx;
    logic [3:0] eix;
    logic [11:0] cnt;
    logic done;
    logic stat_rd;
    logic write_collision_flag;
    logic overrun_flag;
    logic sck;
    logic ss_n;
    logic mosi;
    logic mosi_oe;
  } spms_core_t;

  typedef struct packed {
    logic aw_got;
    logic aw_ok;
    logic [3:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic ar_pend;
    logic ar_ok;
    logic [3:0] araddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic wr;
    logic rd;
  } spms_axil_t;
endpackage

// >>> spms_regif_if.sv
// Register access strobes between the bus slave and the controller core
interface spms_regif_if;
  logic wr;
  logic [3:0] waddr;
  logic [31:0] wdata;
  logic rd;
  logic [3:0] raddr;
  logic [31:0] rdata;
  modport bus (output wr, output waddr, output wdata, output rd, output raddr, input rdata);
  modport core (input wr, input waddr, input wdata, input rd, input raddr, output rdata);
endinterface

// >>> spms_sync.sv
// Two flip-flop synchroniser for pin inputs
module spms_sync #(
  parameter int W = 2
) (
  input wire logic clk, // Sampling clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised outputs
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spms_sync_t;
  spms_sync_t s;
  spms_sync_t next_s;

  // Second stage reads only the first
  always_comb begin
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  // State register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.s2;
endmodule
